// ==== rtl/out_formatter.sv ====
// Operation
// - temperature bit selects internal sensor conversions
// - temperature mode overrides config zero, internal reference
// - 14-bit temperature left-justified in 24 bits
// - result bytes go out least significant first
// - one count is 0.03125 degrees, zero is zero
// - negative temperatures are two's complement
// - counter word only while counter enable set
// - counter byte precedes data on each conversion read
// - counter starts 00h, increments, wraps FFh to 00h
// - counter clears on enable toggle or reset
// - integrity covers register reads and counter word
// - mode 01 appends inverted copy after data
// - mode 10 appends 16-bit checksum after data
// - checksum is ccitt polynomial, preset FFFFh
`timescale 1ns/1ns
module out_formatter
   import out_pkg::*;
(
   input wire logic clock, // 125 MHz system clock
   input wire logic rst, // async reset, active high
   // configuration levels
   input wire logic temp_sense_enable, // 1 selects the temperature sensor
   input wire logic conv_counter_enable, // 1 prefixes the counter word
   input wire logic [1:0] integrity_mode, // 00 none, 01 inverted copy, 10 crc
   input wire logic [3:0] mux_sel_cfg, // input mux from configuration zero
   input wire logic [2:0] gain_cfg, // gain from configuration zero
   input wire logic pga_bypass_cfg, // pga bypass from configuration zero
   input wire logic [1:0] ref_sel_cfg, // selected reference source
   // effective analog front-end setting
   output logic meas_temp, // front end measures the temperature sensor
   output logic [3:0] mux_sel_eff, // mux setting actually applied
   output logic [2:0] gain_eff, // gain actually applied
   output logic pga_bypass_eff, // pga bypass actually applied
   output logic [1:0] ref_sel_eff, // reference actually applied
   // conversion results from the modulator and filter
   input wire logic conv_done, // one-cycle pulse, a conversion finished
   input wire logic [RESULT_W-1:0] conv_data, // analog input result
   input wire logic [TEMP_W-1:0] temp_code, // sensor code, 0.03125 C per count
   // read requests from the command decoder
   input wire logic rd_req, // one-cycle pulse, start a read frame
   input wire logic rd_is_reg, // 1 register read, 0 conversion read
   input wire logic [7:0] reg_data, // register contents for a register read
   output logic rd_ready, // high when a read can be started
   // byte stream to the serial transmitter
   output logic tx_valid, // a byte is offered
   output logic [7:0] tx_data, // byte offered
   input wire logic tx_ready, // transmitter takes the byte
   output logic tx_last // offered byte ends the frame
);

   ////////////////////////////////////////////////////////////////////
   // result capture and conversion counter

   logic [RESULT_W-1:0] result_r;
   logic [RESULT_W-1:0] result_nxt;
   logic [COUNT_W-1:0] count_r;
   logic [COUNT_W-1:0] count_nxt;
   logic [RESULT_W-1:0] temp_result;

   // the sensor code is already signed in 0.03125 C steps, so it goes in
   // untouched at the top; the pad bits carry nothing
   assign temp_result = {temp_code, {TEMP_PAD_W{1'b0}}};

   // a finished conversion replaces the held result; the path follows the
   // applied mode, so a mode change lands with the next finished conversion
   assign result_nxt = conv_done ? (meas_temp ? temp_result : conv_data) : result_r;

   // counter held at zero while disabled, so a clear-then-set restarts it
   // it advances on every finished conversion, read or not, so gaps show misses
   assign count_nxt = !conv_counter_enable ? COUNT_RESET :
                      (conv_done ? count_r + 8'h01 : count_r);

   // result and counter registers; any reset puts the counter back to 00h
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         result_r <= RESULT_RESET;
         count_r <= COUNT_RESET;
      end else begin
         result_r <= result_nxt;
         count_r <= count_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // front-end override in temperature mode

   logic [3:0] mux_nxt;
   logic [2:0] gain_nxt;
   logic pga_nxt;
   logic [1:0] ref_nxt;

   // configuration zero is ignored entirely and the internal reference is
   // forced; registered so the analog side sees a glitch-free setting;
   // the mux code here only matters outside temperature mode, where the
   // sensor path is chosen by meas_temp instead
   assign mux_nxt = temp_sense_enable ? MUX_TEMP : mux_sel_cfg;
   assign gain_nxt = temp_sense_enable ? GAIN_ONE : gain_cfg;
   assign pga_nxt = temp_sense_enable ? 1'b0 : pga_bypass_cfg;
   assign ref_nxt = temp_sense_enable ? REF_INTERNAL : ref_sel_cfg;

   // applied setting registers; the analog side sees one change per edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meas_temp <= 1'b0;
         mux_sel_eff <= 4'h0;
         gain_eff <= 3'h0;
         pga_bypass_eff <= 1'b0;
         ref_sel_eff <= REF_INTERNAL;
      end else begin
         meas_temp <= temp_sense_enable;
         mux_sel_eff <= mux_nxt;
         gain_eff <= gain_nxt;
         pga_bypass_eff <= pga_nxt;
         ref_sel_eff <= ref_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame snapshot taken when a read starts

   logic [8*PAY_BYTES-1:0] pay_r;
   logic [8*PAY_BYTES-1:0] pay_new;
   logic [2:0] npay_r;
   logic [2:0] npay_new;
   logic [1:0] mode_r;
   logic [2:0] body_bytes;
   logic [8*PAY_BYTES-1:0] body_vec;
   logic cnt_lead;

   // body bytes in wire order: register byte, or result lsb first; a read
   // that lands on the same edge as conv_done sends the previous result,
   // which matches the counter byte taken on that edge
   assign body_bytes = rd_is_reg ? NBYTES_REG : NBYTES_CONV;
   assign body_vec = rd_is_reg ? {24'h000000, reg_data} : {8'h00, result_r};

   // the counter byte leads, on conversion reads only, when enabled; a
   // register read never carries it, so the host cannot mistake a register
   // byte for a fresh count
   assign cnt_lead = conv_counter_enable && !rd_is_reg;
   assign pay_new = cnt_lead ? {body_vec[8*PAY_BYTES-9:0], count_r} : body_vec;
   assign npay_new = cnt_lead ? body_bytes + 3'h1 : body_bytes;

   ////////////////////////////////////////////////////////////////////
   // output sequencer
   // one byte is on offer at a time; it moves on only at an edge with ready

   seq_state_t state_r;
   seq_state_t state_nxt;
   logic [1:0] idx_r;
   logic [1:0] idx_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic start;
   logic step;
   logic pay_end;
   logic inv_end;
   logic crc_end;
   logic [CRC_W-1:0] crc_r;
   logic [CRC_W-1:0] crc_nxt;
   logic trail_inv;
   logic trail_crc;

   // byte i of a packed payload
   // the same picker serves the body and its inverted copy
   function automatic logic [7:0] pick(input logic [8*PAY_BYTES-1:0] v, input logic [1:0] i);
      return v[8*i +: 8];
   endfunction

   // frame start, byte handover and end-of-section detection
   assign start = rd_req && (state_r == ST_IDLE);
   assign step = tx_valid && tx_ready;
   assign pay_end = ({1'b0, idx_r} == npay_r - 3'h1);
   assign inv_end = pay_end;
   assign crc_end = (idx_r == CRC_LAST_IDX);

   // trailer kind of the frame in flight, from the mode latched at start;
   // code 11 decodes as neither and so sends a bare frame
   assign trail_inv = (mode_r == INTEG_INVERT);
   assign trail_crc = (mode_r == INTEG_CRC);

   // next state and index; the trailer follows the msb data byte at once
   // a stray state code returns to idle rather than hanging the link
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      unique case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = ST_PAY;
               idx_nxt = 2'h0;
            end
         end
         ST_PAY: begin
            if (step && !pay_end) begin
               idx_nxt = idx_r + 2'h1;
            end else if (step && trail_inv) begin
               state_nxt = ST_INV;
               idx_nxt = 2'h0;
            end else if (step && trail_crc) begin
               state_nxt = ST_CRC;
               idx_nxt = 2'h0;
            end else if (step) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_INV: begin
            if (step && inv_end) begin
               state_nxt = ST_IDLE;
            end else if (step) begin
               idx_nxt = idx_r + 2'h1;
            end
         end
         ST_CRC: begin
            if (step && crc_end) begin
               state_nxt = ST_IDLE;
            end else if (step) begin
               idx_nxt = idx_r + 2'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            idx_nxt = 2'h0;
         end
      endcase
   end

   // byte to present after this edge; data is loaded ahead so tx_data is a flop
   // the crc high byte uses crc_nxt because the last body byte folds in now
   always_comb begin
      data_nxt = data_r;
      if (start) begin
         data_nxt = pick(pay_new, 2'h0);
      end else if (step) begin
         unique case (state_nxt)
            ST_PAY: data_nxt = pick(pay_r, idx_nxt);
            ST_INV: data_nxt = ~pick(pay_r, idx_nxt);
            ST_CRC: data_nxt = (idx_nxt == 2'h0) ? crc_nxt[15:8] : crc_r[7:0];
            ST_IDLE: data_nxt = 8'h00;
            default: data_nxt = 8'h00;
         endcase
      end
   end

   // state, index and the byte on offer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         idx_r <= 2'h0;
         data_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         data_r <= data_nxt;
      end
   end

   // snapshot so a conversion finishing mid-frame cannot tear the bytes
   // the mode is latched too, so changing it mid-frame cannot drop a trailer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pay_r <= 32'h00000000;
         npay_r <= 3'h0;
         mode_r <= INTEG_NONE;
      end else if (start) begin
         pay_r <= pay_new;
         npay_r <= npay_new;
         mode_r <= integrity_mode;
      end
   end

   // checksum runs over counter and data bytes as they leave; folding the
   // byte actually accepted keeps the sum right under any stall, and the
   // counter enters only as the first body byte
   crc16_byte u_crc (
      .clock(clock),
      .rst(rst),
      .init(start),
      .en(step && state_r == ST_PAY),
      .din(data_r),
      .crc_r(crc_r),
      .crc_nxt(crc_nxt)
   );

   ////////////////////////////////////////////////////////////////////
   // handshake outputs

   // valid and ready are pure state decodes, so they change only on an edge
   assign tx_valid = (state_r != ST_IDLE);
   assign tx_data = data_r;
   // a read during a frame is dropped without notice; the host must wait
   // for ready or it loses the request
   assign rd_ready = (state_r == ST_IDLE);

   // last byte: end of a bare body, end of the inverted copy, or crc low byte
   assign tx_last = ((state_r == ST_PAY) && pay_end && !trail_inv && !trail_crc) ||
                    ((state_r == ST_INV) && inv_end) ||
                    ((state_r == ST_CRC) && crc_end);

endmodule

// ==== rtl/out_pkg.sv ====
package out_pkg;

   // byte and word geometry of the output stream
   localparam int RESULT_W = 24;
   localparam int TEMP_W = 14;
   localparam int TEMP_PAD_W = RESULT_W - TEMP_W;
   localparam int COUNT_W = 8;
   localparam int CRC_W = 16;
   localparam int PAY_BYTES = 4;

   // reset and preset values, and the checksum polynomial
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
   localparam logic [CRC_W-1:0] CRC_PRESET = 16'hFFFF;
   localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 24'h000000;

   // integrity mode field codes
   localparam logic [1:0] INTEG_NONE = 2'h0;
   localparam logic [1:0] INTEG_INVERT = 2'h1;
   localparam logic [1:0] INTEG_CRC = 2'h2;

   // reference source code that selects the internal reference
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   // input mux code that routes the temperature sensor
   localparam logic [3:0] MUX_TEMP = 4'h0;
   localparam logic [2:0] GAIN_ONE = 3'h0;

   // byte counts of a frame body, and the index of the last checksum byte
   localparam logic [2:0] NBYTES_CONV = 3'h3;
   localparam logic [2:0] NBYTES_REG = 3'h1;
   localparam logic [1:0] CRC_LAST_IDX = 2'h1;

   // output sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PAY = 4'b0010,
      ST_INV = 4'b0100,
      ST_CRC = 4'b1000
   } seq_state_t;

   // one byte through the ccitt polynomial, msb first
   function automatic logic [CRC_W-1:0] crc_byte(input logic [CRC_W-1:0] crc_in, input logic [7:0] din);
      logic [CRC_W-1:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fb = c[CRC_W-1] ^ din[i];
         c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

endpackage

// ==== rtl/crc16_byte.sv ====
`timescale 1ns/1ns
module crc16_byte
   import out_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic init, // preset the remainder
   input wire logic en, // fold din into the remainder
   input wire logic [7:0] din, // byte in transmission order
   output logic [CRC_W-1:0] crc_r, // remainder so far
   output logic [CRC_W-1:0] crc_nxt // remainder including din when en
);

   logic [CRC_W-1:0] folded;

   // next remainder; init wins so a fresh frame never inherits an old sum
   assign folded = crc_byte(crc_r, din);
   assign crc_nxt = init ? CRC_PRESET : (en ? folded : crc_r);

   // remainder register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crc_r <= CRC_PRESET;
      end else begin
         crc_r <= crc_nxt;
      end
   end

endmodule

// ==== tb/out_check_sva.sv ====
`timescale 1ns/1ns
module out_check
   import out_pkg::*;
(
   input wire logic clock, // clock
   input wire logic rst, // reset
   input wire logic temp_sense_enable, // temp mode
   input wire logic [1:0] integrity_mode, // mode
   input wire logic meas_temp, // temp measured
   input wire logic [3:0] mux_sel_eff, // mux
   input wire logic [2:0] gain_eff, // gain
   input wire logic pga_bypass_eff, // bypass
   input wire logic [1:0] ref_sel_eff, // reference
   input wire logic rd_req, // read
   input wire logic rd_is_reg, // reg read
   input wire logic [7:0] reg_data, // reg value
   input wire logic rd_ready, // idle
   input wire logic tx_valid, // offered
   input wire logic [7:0] tx_data, // byte
   input wire logic tx_ready, // taken
   input wire logic tx_last // last
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // sensor select follows the enable one cycle later
   property p_ts; meas_temp == $past(temp_sense_enable); endproperty
   a_ts: assert property (p_ts) else $error("meas_temp lags wrong");
   // temperature mode overrides the front end and reference
   property p_ref; meas_temp |-> ref_sel_eff == REF_INTERNAL; endproperty
   a_ref: assert property (p_ref) else $error("reference not internal");
   property p_cfg; meas_temp |-> mux_sel_eff == MUX_TEMP && gain_eff == GAIN_ONE && !pga_bypass_eff; endproperty
   a_cfg: assert property (p_cfg) else $error("config zero not ignored");
   ////////////////////////////////////////////////////////////
   // frame framing at the byte stream
   property p_start; rd_req && rd_ready |=> tx_valid; endproperty
   a_start: assert property (p_start) else $error("frame did not start");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_hold: assert property (p_hold) else $error("byte dropped under stall");
   property p_end; tx_valid && tx_ready && tx_last |=> !tx_valid && rd_ready; endproperty
   a_end: assert property (p_end) else $error("frame did not end");
   property p_idle; !tx_valid |-> rd_ready; endproperty
   a_idle: assert property (p_idle) else $error("idle but not ready");
   property p_quiet; rd_ready && !rd_req |=> !tx_valid; endproperty
   a_quiet: assert property (p_quiet) else $error("frame started without a read");
   // a register read carries one byte and never the counter
   property p_reg; rd_req && rd_ready && rd_is_reg |=> tx_data == $past(reg_data); endproperty
   a_reg: assert property (p_reg) else $error("register byte wrong");
   property p_reg1; rd_req && rd_ready && rd_is_reg && integrity_mode == INTEG_NONE |=> tx_last; endproperty
   a_reg1: assert property (p_reg1) else $error("register frame too long");
endmodule

// ==== tb/host_reader.sv ====
`timescale 1ns/1ns
module host_reader (
   input wire logic clock, // clock
   input wire logic slow, // stall every other cycle
   input wire logic tx_valid, // byte offered
   input wire logic [7:0] tx_data, // byte
   input wire logic tx_last, // last byte
   output logic tx_ready // accept
);
   logic [7:0] got[$];
   int n_frames = 0;
   // a slow host drops ready on alternate cycles to exercise the hold
   initial begin
      tx_ready = 1'b1;
      forever @(posedge clock) begin
         if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last) n_frames++;
         end
         tx_ready <= slow ? ~tx_ready : 1'b1;
      end
   end
endmodule

// ==== tb/conversion_output_integrity_bench.sv ====
`timescale 1ns/1ns
module conversion_output_integrity_bench;
   import out_pkg::*;
   logic clock, rst, tse, cce, conv_done, rd_req, rd_is_reg, slow;
   logic [1:0] imode;
   logic [23:0] conv_data;
   logic [13:0] temp_code;
   logic [7:0] reg_data, tx_data;
   logic rd_ready, tx_valid, tx_ready, tx_last;
   int n_errors = 0;
   int comparisons = 0;
   logic [7:0] prev_cnt;
   out_formatter u_out_formatter(.clock(clock), .rst(rst), .temp_sense_enable(tse), .conv_counter_enable(cce),
      .integrity_mode(imode), .mux_sel_cfg(4'hA), .gain_cfg(3'h5), .pga_bypass_cfg(1'b1), .ref_sel_cfg(2'h2),
      .meas_temp(), .mux_sel_eff(), .gain_eff(), .pga_bypass_eff(), .ref_sel_eff(), .conv_done(conv_done),
      .conv_data(conv_data), .temp_code(temp_code), .rd_req(rd_req), .rd_is_reg(rd_is_reg), .reg_data(reg_data),
      .rd_ready(rd_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_last(tx_last));
   host_reader u_host_reader(.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////
   task cyc;
      @(posedge clock);
      #1;
   endtask
   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // n conversions back to back; the strobe stays up between them
   task conv(input logic [23:0] d, input logic [13:0] t, input int n);
      conv_data = d;
      temp_code = t;
      conv_done = 1'b1;
      repeat (n) cyc;
      conv_done = 1'b0;
   endtask
   // host side long division, preset all ones, msb of each byte first
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         for (int j = 7; j >= 0; j--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? 16'h1021 : 16'h0000);
         end
      end
      return c;
   endfunction
   // issue one read frame, collect it and compare with body plus integrity bytes
   task rd(input logic isr, input logic [7:0] rv, input logic [1:0] m, input logic [7:0] body[$]);
      logic [7:0] exp[$];
      logic [7:0] rx_body[$];
      logic [15:0] crc_exp;
      logic [15:0] crc_rx;
      logic [15:0] crc_got;
      int k, n0, nb;
      exp = body;
      nb = body.size();
      crc_exp = crc16(body);
      if (m == INTEG_INVERT) begin
         foreach (body[i]) exp.push_back(~body[i]);
      end
      if (m == INTEG_CRC) begin
         exp.push_back(crc_exp[15:8]);
         exp.push_back(crc_exp[7:0]);
      end
      u_host_reader.got.delete();
      n0 = u_host_reader.n_frames;
      imode = m;
      rd_is_reg = isr;
      reg_data = rv;
      rd_req = 1'b1;
      cyc;
      rd_req = 1'b0;
      for (k = 0; k < 200 && u_host_reader.n_frames == n0; k++) cyc;
      if (k == 200) begin
         $display("mismatch at %0t frame hang %h %h", $time, 1'b0, 1'b1);
         n_errors++;
         give_verdict;
      end
      cyc;
      comparisons++;
      if (u_host_reader.got.size() != exp.size()) begin
         $display("mismatch at %0t length %h %h", $time, u_host_reader.got.size(), exp.size());
         n_errors++;
      end else begin
         foreach (exp[i]) begin
            comparisons++;
            if (u_host_reader.got[i] !== exp[i]) begin
               $display("mismatch at %0t byte %0d %h %h", $time, i, u_host_reader.got[i], exp[i]);
               n_errors++;
            end
         end
      end
      // the host folds what it received; a miss is a corrupted frame to read again
      if (m == INTEG_CRC && u_host_reader.got.size() == exp.size()) begin
         rx_body.delete();
         for (int i = 0; i < nb; i++) rx_body.push_back(u_host_reader.got[i]);
         crc_rx = crc16(rx_body);
         crc_got = {u_host_reader.got[nb], u_host_reader.got[nb+1]};
         comparisons++;
         if (crc_got !== crc_rx) begin
            $display("mismatch at %0t received checksum %h %h", $time, crc_got, crc_rx);
            n_errors++;
         end
      end
   endtask
   // host view of the counter: equal means stale, a gap above one means misses
   task cnt_gap(input logic [7:0] want);
      logic [7:0] gap;
      gap = u_host_reader.got[0] - prev_cnt;
      prev_cnt = u_host_reader.got[0];
      comparisons++;
      if (gap !== want) begin
         $display("mismatch at %0t counter gap %h %h", $time, gap, want);
         n_errors++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task s_plain;
      conv(24'h123456, 14'h0000, 1);
      rd(0, 8'h00, INTEG_NONE, {8'h56, 8'h34, 8'h12});
   endtask
   task s_count_inv;
      cce = 1'b1;
      cyc;
      slow = 1'b1;
      conv(24'h123456, 14'h0000, 3);
      rd(0, 8'h00, INTEG_INVERT, {8'h03, 8'h56, 8'h34, 8'h12});
      cnt_gap(8'h03);
      slow = 1'b0;
   endtask
   task s_crc;
      rd(0, 8'h00, INTEG_CRC, {8'h03, 8'h56, 8'h34, 8'h12});
      cnt_gap(8'h00);
      rd(1, 8'hA5, INTEG_CRC, {8'hA5});
      rd(1, 8'h3C, INTEG_NONE, {8'h3C});
      rd(1, 8'hC3, 2'h3, {8'hC3});
   endtask
   task s_wrap;
      conv(24'h0000AB, 14'h0000, 253);
      rd(0, 8'h00, INTEG_NONE, {8'h00, 8'hAB, 8'h00, 8'h00});
      cnt_gap(8'hFD);
   endtask
   task s_clear;
      conv(24'h0000AB, 14'h0000, 2);
      cce = 1'b0;
      cyc;
      cce = 1'b1;
      cyc;
      rd(0, 8'h00, INTEG_NONE, {8'h00, 8'hAB, 8'h00, 8'h00});
      conv(24'h0000AB, 14'h0000, 2);
      rst = 1'b1;
      cyc;
      rst = 1'b0;
      cyc;
      rd(0, 8'h00, INTEG_NONE, {8'h00, 8'h00, 8'h00, 8'h00});
   endtask
   task s_temp;
      cce = 1'b0;
      tse = 1'b1;
      repeat (2) cyc;
      conv(24'h123456, 14'h3CE0, 1);
      rd(0, 8'h00, INTEG_NONE, {8'h00, 8'h80, 8'hF3});
      conv(24'h123456, 14'h0001, 1);
      rd(0, 8'h00, INTEG_NONE, {8'h00, 8'h04, 8'h00});
      tse = 1'b0;
      cyc;
   endtask
   initial begin
      rst = 1'b1;
      tse = 1'b0;
      cce = 1'b0;
      conv_done = 1'b0;
      rd_req = 1'b0;
      rd_is_reg = 1'b0;
      slow = 1'b0;
      imode = INTEG_NONE;
      conv_data = 24'h000000;
      temp_code = 14'h0000;
      reg_data = 8'h00;
      prev_cnt = 8'h00;
      repeat (16) cyc;
      rst = 1'b0;
      cyc;
      s_plain;
      s_count_inv;
      s_crc;
      s_wrap;
      s_clear;
      s_temp;
      give_verdict;
   end
endmodule
bind out_formatter out_check u_out_check(.clock(clock), .rst(rst), .temp_sense_enable(temp_sense_enable),
   .integrity_mode(integrity_mode), .meas_temp(meas_temp), .mux_sel_eff(mux_sel_eff), .gain_eff(gain_eff),
   .pga_bypass_eff(pga_bypass_eff), .ref_sel_eff(ref_sel_eff), .rd_req(rd_req), .rd_is_reg(rd_is_reg),
   .reg_data(reg_data), .rd_ready(rd_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
   .tx_last(tx_last));
